// ==== hw/twc_pkg.sv ====
package twc_pkg;

	// device address field and transfer-type codes of the address byte
	localparam logic [5:0] DEV_ADDR    = 6'h06;
	localparam logic [1:0] TYPE_WRITE  = 2'h2;
	localparam logic [1:0] TYPE_READ   = 2'h3;

	// register addresses inside the device
	localparam logic [6:0] REG_SOUND    = 7'h10;
	localparam logic [6:0] REG_CTRL     = 7'h11;
	localparam logic [6:0] REG_STATUS   = 7'h20;
	localparam logic [6:0] REG_DEFAULTS = 7'h7F;

	// byte and bit positions within a frame
	localparam logic [1:0] BYTE_ADDR = 2'h0;
	localparam logic [1:0] BYTE_HI   = 2'h1;
	localparam logic [1:0] BYTE_LO   = 2'h2;
	localparam logic [1:0] BYTE_END  = 2'h3;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST  = 3'h7;

	// synchroniser geometry
	localparam int         SYNC_N      = 4;
	localparam logic [1:0] SYNC_SETTLE = 2'h3;
	localparam int         SYNC_STRAP  = 0;
	localparam int         SYNC_MUTE   = 1;
	localparam int         SYNC_WR     = 2;
	localparam int         SYNC_PREP   = 3;

	// de-emphasis code meaning off
	localparam logic [1:0] DEEMPH_OFF = 2'h0;

	// sound register layout
	typedef struct packed {
		logic [1:0] rsvd;
		logic [1:0] filter_mode;
		logic [1:0] treble;
		logic [3:0] bass;
		logic [5:0] volume;
	} twc_sound_t;

	// control register layout
	typedef struct packed {
		logic [10:0] rsvd;
		logic        power_on;
		logic [1:0]  deemph;
		logic        auto_silence_enable;
		logic        soft_mute_bit;
	} twc_ctrl_t;

	// all writable settings
	typedef struct packed {
		twc_sound_t sound;
		twc_ctrl_t  ctrl;
	} twc_settings_t;

	// status word, also the readable status register
	typedef struct packed {
		logic [6:0] rsvd;
		logic [1:0] clock_precision_code;
		logic       pre_emphasis;
		logic       pcm_valid;
		logic [1:0] sample_rate_code;
		logic       input_locked;
		logic       pll_locked;
		logic       interp_muted;
	} twc_status_t;

	// start-up values, shared by both control styles
	localparam twc_sound_t    DEF_SOUND    = 16'h0000;
	localparam twc_ctrl_t     DEF_CTRL     = 16'h0013;
	localparam twc_settings_t DEF_SETTINGS = {DEF_SOUND, DEF_CTRL};
	localparam logic [15:0]   SOUND_MASK   = 16'h3FFF;
	localparam logic [15:0]   CTRL_MASK    = 16'h001F;

	// selection state after an address byte
	typedef enum logic [2:0] {
		SEL_NONE  = 3'b001,
		SEL_WRITE = 3'b010,
		SEL_READ  = 3'b100
	} twc_sel_t;

endpackage

// ==== hw/twc_ctrl_port.sv ====
// Overview of operation
// [RL1] static style uses serial start-up defaults for everything no pin sets; here de-emphasis follows the input pre-emphasis status
// [RL2] board ties strap high for static pins, low for serial control
// [RL3] sync output high only with clock, decoder locked and PCM data
// [RL4] in static style the board holds serial lines low
// [RL5] in serial style the bus master drives the serial lines
// [RL6] serial style starts with soft mute set until controller clears it
// [RL7] serially written de-emphasis applies only in serial style
// [RL8] status word with lock, rate, PCM, emphasis, precision is readable
// [RL9] sound, control and restore-defaults settings are serially writable
// [RL10] every byte moves least significant bit first, both directions
// [RL11] address phase: mode low, eight clock pulses, one bit each
// [RL12] address byte decides whether the device takes the next data phase
// [RL13] data phase: mode high, one or more address, instruction or data bytes
// [RL14] transfers are either writes to the device or reads from it
// [RL15] one wake-up clock pulse precedes the first transfer after power-up
// [RL16] mute pin or soft mute bit requests a cosine roll-off mute; here the pin acts in static style only, the bit in serial style only
// [RL17] controller clears soft mute bit before audio is heard
// [RL18] address byte: type code in bits 0-1, device address in 2-7
// [RL19] first data byte: bit 0 read or write, bits 1-7 register
// [RL20] data sampled on rising clock; pulses ignored while not selected
// [RL21] every mode line change restarts the bit counter
`timescale 1ns/1ps
module twc_ctrl_port
(
	// core clock and reset
	input  wire logic                   clock_i,
	input  wire logic                   rstn_i,
	// strap and static pins
	input  wire logic                   control_style_strap_i,
	input  wire logic                   mute_pin_i,
	// serial control link
	input  wire logic                   ctrl_serial_clock_i,
	input  wire logic                   ctrl_frame_phase_i,
	input  wire logic                   ctrl_serial_data_i,
	output logic                        ctrl_serial_data_o,
	output logic                        ctrl_serial_data_oe_o,
	// receiver status from the datapath
	input  wire twc_pkg::twc_status_t   status_i,
	// effective settings and status out
	output twc_pkg::twc_settings_t      settings_o,
	output logic                        static_mode_o,
	output logic                        lock_o
);

	// ---------------- link domain ----------------
	logic                  awake;
	logic                  last_mode;
	logic [2:0]            bit_cnt;
	logic [7:0]            shift;
	twc_pkg::twc_sel_t     sel;
	logic [1:0]            byte_cnt;
	logic [6:0]            reg_addr;
	logic [6:0]            rd_addr;
	logic [7:0]            data_hi;
	logic [7:0]            out_shift;
	logic                  out_oe;
	logic                  wr_tgl;
	logic                  prep_tgl;
	twc_pkg::twc_settings_t link_set;

	// core-domain snapshot read by the link (stable by handshake)
	twc_pkg::twc_status_t  status_snap;

	// byte assembly and phase decode
	wire        mode_change = ctrl_frame_phase_i != last_mode;
	wire [2:0]  cnt_eff     = mode_change ? twc_pkg::BIT_FIRST : bit_cnt;   // [RL21]
	wire [7:0]  next_shift  = {ctrl_serial_data_i, shift[7:1]};             // [RL10]
	wire        byte_done   = cnt_eff == twc_pkg::BIT_LAST;
	wire        addr_phase  = !ctrl_frame_phase_i;                          // [RL11]
	wire        data_phase  = ctrl_frame_phase_i;                           // [RL13]
	wire        take_bit    = awake && (addr_phase || sel != twc_pkg::SEL_NONE); // [RL20]
	wire        addr_done   = take_bit && addr_phase && byte_done;
	wire        dev_match   = next_shift[7:2] == twc_pkg::DEV_ADDR;         // [RL18]
	wire [1:0]  xfer_type   = next_shift[1:0];
	wire        wr_byte     = take_bit && data_phase && byte_done && sel == twc_pkg::SEL_WRITE;
	wire        rd_edge     = take_bit && data_phase && sel == twc_pkg::SEL_READ;
	wire [15:0] wr_word     = {data_hi, next_shift};
	wire        restore     = reg_addr == twc_pkg::REG_DEFAULTS;

	// read-back selection
	wire        rd_status   = rd_addr == twc_pkg::REG_STATUS;
	wire        rd_sound    = rd_addr == twc_pkg::REG_SOUND;
	wire        rd_ctrl     = rd_addr == twc_pkg::REG_CTRL;
	wire        rd_valid    = rd_status || rd_sound || rd_ctrl;
	wire [15:0] rd_word     = rd_status ? status_snap :                     // [RL8]
	                          rd_sound  ? link_set.sound :
	                          rd_ctrl   ? link_set.ctrl : 16'h0000;
	wire [7:0]  rd_first    = {rd_addr, !rd_valid};                         // [RL19]

	// next selection after an address byte
	twc_pkg::twc_sel_t next_sel;
	always_comb
	begin
		next_sel = twc_pkg::SEL_NONE;
		if (dev_match)
		begin
			case (xfer_type)                                                // [RL12]
				twc_pkg::TYPE_WRITE: next_sel = twc_pkg::SEL_WRITE;
				twc_pkg::TYPE_READ:  next_sel = twc_pkg::SEL_READ;
				default:             next_sel = twc_pkg::SEL_NONE;
			endcase
		end
	end

	// wake-up, mode tracking and bit counter
	always_ff @(posedge ctrl_serial_clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			awake     <= 1'b0;
			last_mode <= 1'b0;
			bit_cnt   <= twc_pkg::BIT_FIRST;
			shift     <= 8'h00;
		end
		else
		begin
			awake     <= 1'b1;                                              // [RL15]
			last_mode <= ctrl_frame_phase_i;
			if (take_bit)
			begin
				bit_cnt <= cnt_eff + 3'h1;
				shift   <= next_shift;
			end
			else if (mode_change)
				bit_cnt <= twc_pkg::BIT_FIRST;                              // [RL21]
		end
	end

	// selection and byte position within the data phase
	always_ff @(posedge ctrl_serial_clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sel      <= twc_pkg::SEL_NONE;
			byte_cnt <= twc_pkg::BYTE_ADDR;
		end
		else if (addr_done)
		begin
			sel      <= next_sel;
			byte_cnt <= twc_pkg::BYTE_ADDR;
		end
		else if (take_bit && data_phase && byte_done && byte_cnt != twc_pkg::BYTE_END)
			byte_cnt <= byte_cnt + 2'h1;
	end

	// write path: register address, prepare read, data bytes
	always_ff @(posedge ctrl_serial_clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			reg_addr <= 7'h00;
			rd_addr  <= 7'h00;
			data_hi  <= 8'h00;
			prep_tgl <= 1'b0;
			wr_tgl   <= 1'b0;
			link_set <= twc_pkg::DEF_SETTINGS;                              // [RL6]
		end
		else if (wr_byte)                                                   // [RL14]
		begin
			case (byte_cnt)
				twc_pkg::BYTE_ADDR:
				begin
					reg_addr <= next_shift[7:1];                            // [RL19]
					if (next_shift[0])
					begin
						rd_addr  <= next_shift[7:1];
						prep_tgl <= !prep_tgl;
					end
				end
				twc_pkg::BYTE_HI: data_hi <= next_shift;
				twc_pkg::BYTE_LO:
				begin
					wr_tgl <= !wr_tgl;                                      // [RL9]
					if (restore)
						link_set <= twc_pkg::DEF_SETTINGS;
					else if (reg_addr == twc_pkg::REG_SOUND)
						link_set.sound <= wr_word & twc_pkg::SOUND_MASK;
					else if (reg_addr == twc_pkg::REG_CTRL)
						link_set.ctrl <= wr_word & twc_pkg::CTRL_MASK;
				end
				default: data_hi <= data_hi;
			endcase
		end
	end

	// read path: reply address byte, then high and low data bytes
	always_ff @(posedge ctrl_serial_clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			out_shift <= 8'h00;
			out_oe    <= 1'b0;
		end
		else if (addr_done && next_sel == twc_pkg::SEL_READ)
		begin
			out_shift <= rd_first;
			out_oe    <= 1'b1;
		end
		else if (addr_phase)
			out_oe <= 1'b0;
		else if (rd_edge && byte_done)
		begin
			case (byte_cnt)
				twc_pkg::BYTE_ADDR: out_shift <= rd_word[15:8];
				twc_pkg::BYTE_HI:   out_shift <= rd_word[7:0];
				default:            out_oe    <= 1'b0;
			endcase
		end
		else if (rd_edge)
			out_shift <= {1'b0, out_shift[7:1]};                            // [RL10]
	end

	assign ctrl_serial_data_o    = out_shift[0];
	assign ctrl_serial_data_oe_o = out_oe;

	// ---------------- core domain ----------------
	logic [2:0]        sync_q [twc_pkg::SYNC_N];
	logic [twc_pkg::SYNC_N-1:0] sync_ok;
	logic [twc_pkg::SYNC_N-1:0] sync_lvl;
	logic [1:0]        settle;
	logic              static_mode;
	logic              mute_pin;
	logic              wr_seen;
	logic              prep_seen;
	twc_pkg::twc_settings_t serial_set;

	wire [twc_pkg::SYNC_N-1:0] async_in = {prep_tgl, wr_tgl, mute_pin_i, control_style_strap_i};

	// three-stage synchronisers, second and third must agree
	for (genvar g = 0; g < twc_pkg::SYNC_N; g++)
	begin : g_sync
		always_ff @(posedge clock_i or negedge rstn_i)
		begin
			if (!rstn_i)
				sync_q[g] <= 3'h0;
			else
				sync_q[g] <= {sync_q[g][1:0], async_in[g]};
		end
		assign sync_ok[g]  = sync_q[g][1] == sync_q[g][2];
		assign sync_lvl[g] = sync_q[g][2];
	end

	// events and levels after the synchronisers have filled
	wire primed   = settle == twc_pkg::SYNC_SETTLE;
	wire strap_ok = primed && sync_ok[twc_pkg::SYNC_STRAP];
	wire mute_ok  = primed && sync_ok[twc_pkg::SYNC_MUTE];
	wire wr_evt   = primed && sync_ok[twc_pkg::SYNC_WR] && sync_lvl[twc_pkg::SYNC_WR] != wr_seen;
	wire prep_evt = primed && sync_ok[twc_pkg::SYNC_PREP]
	                && sync_lvl[twc_pkg::SYNC_PREP] != prep_seen;

	// strap and mute pin levels, toggle bookkeeping
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			settle      <= 2'h0;
			static_mode <= 1'b1;
			mute_pin    <= 1'b0;
			wr_seen     <= 1'b0;
			prep_seen   <= 1'b0;
		end
		else
		begin
			if (!primed)
				settle <= settle + 2'h1;
			if (strap_ok)
				static_mode <= sync_lvl[twc_pkg::SYNC_STRAP];               // [RL2]
			if (mute_ok)
				mute_pin <= sync_lvl[twc_pkg::SYNC_MUTE];
			if (wr_evt)
				wr_seen <= sync_lvl[twc_pkg::SYNC_WR];
			if (prep_evt)
				prep_seen <= sync_lvl[twc_pkg::SYNC_PREP];
		end
	end

	// serial settings copy and status snapshot, taken on handshake events
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			serial_set  <= twc_pkg::DEF_SETTINGS;                           // [RL6]
			status_snap <= 16'h0000;
		end
		else
		begin
			if (static_mode)
				serial_set <= twc_pkg::DEF_SETTINGS;
			else if (wr_evt)
				serial_set <= link_set;
			if (prep_evt)
				status_snap <= status_i;                                    // [RL8]
			status_snap.rsvd <= '0;                                         // reserved bits read zero
		end
	end

	// static style: defaults, mute pin and automatic de-emphasis
	twc_pkg::twc_settings_t static_set;
	always_comb
	begin
		static_set                    = twc_pkg::DEF_SETTINGS;              // [RL1]
		static_set.ctrl.soft_mute_bit = mute_pin;                           // [RL16]
		static_set.ctrl.deemph        = status_i.pre_emphasis ?             // [RL7]
		                                status_i.sample_rate_code : twc_pkg::DEEMPH_OFF;
	end

	wire twc_pkg::twc_settings_t next_settings = static_mode ? static_set : serial_set;
	wire next_lock = status_i.pll_locked && status_i.input_locked && status_i.pcm_valid;

	// registered outputs
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			settings_o    <= twc_pkg::DEF_SETTINGS;
			static_mode_o <= 1'b1;
			lock_o        <= 1'b0;
		end
		else
		begin
			settings_o    <= next_settings;
			static_mode_o <= static_mode;
			lock_o        <= next_lock;                                     // [RL3]
		end
	end

	// ---------------- checks ----------------
	a_lock_follows: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RL3]
		$past(rstn_i) |-> lock_o == $past(next_lock))
		else $error("sync output does not follow lock and pcm status");

	a_static_defaults: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RL1]
		static_mode_o |-> settings_o.sound == twc_pkg::DEF_SOUND
		&& settings_o.ctrl.power_on == twc_pkg::DEF_CTRL.power_on)
		else $error("static style does not use default settings");

	a_deemph_static: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RL7]
		(static_mode && !status_i.pre_emphasis)
		|=> settings_o.ctrl.deemph == twc_pkg::DEEMPH_OFF)
		else $error("serial de-emphasis leaked into static style");

	a_mute_held: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RL6]
		(!static_mode && !static_mode_o && serial_set.ctrl.soft_mute_bit && !wr_evt)
		|=> settings_o.ctrl.soft_mute_bit)
		else $error("soft mute dropped without a serial write");

	a_mute_pin: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RL16]
		(static_mode && $stable(mute_pin)) |=> settings_o.ctrl.soft_mute_bit == $past(mute_pin))
		else $error("mute pin does not reach soft mute request");

	a_mode_restart: assert property (@(posedge ctrl_serial_clock_i) disable iff (!rstn_i) // [RL21]
		(awake && mode_change && addr_phase) |=> bit_cnt == 3'h1)
		else $error("mode change did not restart bit counter");

	a_select_byte: assert property (@(posedge ctrl_serial_clock_i) disable iff (!rstn_i) // [RL12]
		(addr_done && dev_match && xfer_type == twc_pkg::TYPE_READ) |=> sel == twc_pkg::SEL_READ
		&& out_oe && ctrl_serial_data_o == !$past(rd_valid))
		else $error("address byte did not select read");

	a_ignore_unsel: assert property (@(posedge ctrl_serial_clock_i) disable iff (!rstn_i) // [RL20]
		(data_phase && sel == twc_pkg::SEL_NONE && !mode_change) |=> $stable(byte_cnt)
		&& $stable(wr_tgl) && !out_oe)
		else $error("clock pulses counted while not selected");

	a_lsb_out: assert property (@(posedge ctrl_serial_clock_i) disable iff (!rstn_i) // [RL10]
		(rd_edge && !byte_done && out_oe) |=> ctrl_serial_data_o == $past(out_shift[1]))
		else $error("read data not shifted lsb first");

	a_eight_bits: assert property (@(posedge ctrl_serial_clock_i) disable iff (!rstn_i) // [RL11]
		(awake && addr_phase && mode_change) ##1 (addr_phase && !mode_change) [*6]
		|=> addr_phase |-> addr_done)
		else $error("address byte not complete after eight pulses");

endmodule

// ==== bench/twc_host_model.sv ====
`timescale 1ns/1ps
module twc_host_model
(
	// serial lines toward the device
	output logic      ctrl_serial_clock_o,
	output logic      ctrl_frame_phase_o,
	output logic      ctrl_serial_data_o,
	// resolved data line level
	input  wire logic line_i
);
	// link clock stands low between frames
	initial
	begin
		ctrl_serial_clock_o = 1'b0;
		ctrl_frame_phase_o  = 1'b0;
		ctrl_serial_data_o  = 1'b0;
	end

	// single pulse that opens the link after power-up
	task automatic wake();
		#62.5 ctrl_serial_clock_o = 1'b1;
		#62.5 ctrl_serial_clock_o = 1'b0;
	endtask

	// one byte, bit 0 first, 125 ns per bit; reply bits taken 0.5 ns before each rising edge
	task automatic xfer(input logic mode, input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 0; i < 8; i++)
		begin
			ctrl_frame_phase_o = mode;
			ctrl_serial_data_o = tx[i];
			#62 rx[i] = line_i;
			#0.5 ctrl_serial_clock_o = 1'b1;
			#62.5 ctrl_serial_clock_o = 1'b0;
		end
	endtask

	// all lines low, as the board holds them in static style
	task automatic idle();
		ctrl_frame_phase_o = 1'b0;
		ctrl_serial_data_o = 1'b0;
	endtask
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic                   clock_i;
	logic                   rstn_i;
	logic                   strap;
	logic                   mute;
	twc_pkg::twc_status_t   status;
	twc_pkg::twc_settings_t settings;
	logic                   h_clk;
	logic                   h_mode;
	logic                   h_data;
	logic                   d_data;
	logic                   d_oe;
	logic                   static_mode;
	logic                   lock;
	logic                   line;
	int                     errors;
	int                     compares;

	// wire level: device wins while it drives
	assign line = d_oe ? d_data : h_data;

	twc_ctrl_port dut
	(
		.clock_i               (clock_i),
		.rstn_i                (rstn_i),
		.control_style_strap_i (strap),
		.mute_pin_i            (mute),
		.ctrl_serial_clock_i   (h_clk),
		.ctrl_frame_phase_i    (h_mode),
		.ctrl_serial_data_i    (line),
		.ctrl_serial_data_o    (d_data),
		.ctrl_serial_data_oe_o (d_oe),
		.status_i              (status),
		.settings_o            (settings),
		.static_mode_o         (static_mode),
		.lock_o                (lock)
	);

	twc_host_model host
	(
		.ctrl_serial_clock_o (h_clk),
		.ctrl_frame_phase_o  (h_mode),
		.ctrl_serial_data_o  (h_data),
		.line_i              (line)
	);

	// 200 MHz core clock
	initial clock_i = 1'b0;
	always #2.5 clock_i = ~clock_i;

	task automatic finish_test();
		if (errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// bounded wait for the settings to reach a value
	task automatic wait_set(input logic [31:0] exp);
		int n;
		n = 0;
		while (settings !== exp && n < 200)
		begin
			@(negedge clock_i);
			n++;
		end
		chk({16'h0, settings}, {16'h0, exp});
		if (n == 200)
			finish_test();
	endtask

	// address byte, register byte, then two data bytes on a write
	task automatic frame(input logic [7:0] a, input logic [6:0] r, input logic rd,
			input logic [15:0] d);
		logic [7:0] rx;
		host.xfer(1'b0, a, rx);
		host.xfer(1'b1, {r, rd}, rx);
		if (!rd)
		begin
			host.xfer(1'b1, d[15:8], rx);
			host.xfer(1'b1, d[7:0], rx);
		end
	endtask

	task automatic wr(input logic [6:0] r, input logic [15:0] d);
		frame({twc_pkg::DEV_ADDR, twc_pkg::TYPE_WRITE}, r, 1'b0, d);
	endtask

	// prepare, then read three reply bytes while the host line toggles
	task automatic rd_chk(input logic [6:0] r, input logic bad, input logic [15:0] exp);
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
		frame({twc_pkg::DEV_ADDR, twc_pkg::TYPE_WRITE}, r, 1'b1, 16'h0);
		#125;
		host.xfer(1'b0, {twc_pkg::DEV_ADDR, twc_pkg::TYPE_READ}, b0);
		host.xfer(1'b1, 8'hAA, b0);
		host.xfer(1'b1, 8'hAA, b1);
		host.xfer(1'b1, 8'hAA, b2);
		chk({24'h0, b0, b1, b2}, {24'h0, r, bad, exp});
		chk({47'h0, d_oe}, 48'h0);
	endtask

	initial
	begin
		errors = 0;
		compares = 0;
		rstn_i = 1'b0;
		strap = 1'b0;
		mute = 1'b0;
		status = 16'hFE6B;
		repeat (3) @(negedge clock_i);
		chk({16'h0, settings}, {16'h0, twc_pkg::DEF_SETTINGS});
		chk({46'h0, d_oe, lock}, 48'h0);
		rstn_i = 1'b1;
		wait_set(twc_pkg::DEF_SETTINGS);
		repeat (10) @(negedge clock_i);
		chk({47'h0, static_mode}, 48'h0);
		// lock output over every lock and PCM combination
		for (int k = 0; k < 8; k++)
		begin
			status.pll_locked = k[0];
			status.input_locked = k[1];
			status.pcm_valid = k[2];
			repeat (2) @(negedge clock_i);
			chk({47'h0, lock}, {47'h0, k == 7});
		end
		status = 16'hFFEB;
		host.wake();
		wr(twc_pkg::REG_CTRL, 16'h0016);
		wait_set({twc_pkg::DEF_SOUND, 16'h0016});
		wr(twc_pkg::REG_SOUND, 16'hFABC);
		wait_set({16'h3ABC, 16'h0016});
		// wrong device address and unused type codes must not select
		frame({twc_pkg::DEV_ADDR ^ 6'h01, twc_pkg::TYPE_WRITE}, twc_pkg::REG_CTRL, 1'b0,
				16'h0001);
		frame({twc_pkg::DEV_ADDR, 2'h0}, twc_pkg::REG_CTRL, 1'b0, 16'h0001);
		frame({twc_pkg::DEV_ADDR, 2'h1}, twc_pkg::REG_CTRL, 1'b0, 16'h0001);
		rd_chk(twc_pkg::REG_CTRL, 1'b0, 16'h0016);
		rd_chk(twc_pkg::REG_STATUS, 1'b0, 16'h01EB);
		rd_chk(7'h05, 1'b1, 16'h0000);
		wr(twc_pkg::REG_DEFAULTS, 16'h0000);
		wait_set(twc_pkg::DEF_SETTINGS);
		// serial de-emphasis that static style must ignore
		wr(twc_pkg::REG_CTRL, 16'h000C);
		wait_set({twc_pkg::DEF_SOUND, 16'h000C});
		// static style: mute from pin, de-emphasis from input status
		host.idle();
		status.pre_emphasis = 1'b1;
		status.sample_rate_code = 2'h2;
		mute = 1'b1;
		strap = 1'b1;
		wait_set({twc_pkg::DEF_SOUND, 16'h001B});
		chk({47'h0, static_mode}, 48'h1);
		mute = 1'b0;
		wait_set({twc_pkg::DEF_SOUND, 16'h001A});
		status.pre_emphasis = 1'b0;
		wait_set({twc_pkg::DEF_SOUND, 16'h0012});
		strap = 1'b0;
		wait_set(twc_pkg::DEF_SETTINGS);
		finish_test();
	end
endmodule
